// ===== design/tsa_pkg.sv
package tsa_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [8:0] ADDR_COMMAND     = 9'h100;
  localparam logic [8:0] ADDR_GLOBAL_MODE = 9'h101;
  localparam logic [8:0] ADDR_TDM_MODE    = 9'h102;
  localparam logic [8:0] ADDR_CLOCK_ROUTE = 9'h103;
  localparam logic [8:0] ADDR_STATUS      = 9'h104;

  // ----------------------------------------------------------------
  // routing memory layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RX_CUR_BASE = 8'h00;
  localparam logic [7:0] RX_SHD_BASE = 8'h40;
  localparam logic [7:0] TX_CUR_BASE = 8'h80;
  localparam logic [7:0] TX_SHD_BASE = 8'hc0;
  localparam logic [7:0] ROUTE_SPAN  = 8'h40;
  localparam int         ENTRY_W     = 16;

  // ----------------------------------------------------------------
  // command and global mode values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SWITCH_FIRST = 8'hc0;
  localparam logic [7:0] GMODE_FIRST_ON   = 8'h05;

  // ----------------------------------------------------------------
  // tdm mode field positions and reset values
  // ----------------------------------------------------------------
  localparam int TX_SYNC_DELAY_LSB = 0;
  localparam int GM_BIT   = 2;
  localparam int FE_BIT   = 3;
  localparam int CE_BIT   = 4;
  localparam int STZ_BIT  = 5;
  localparam int CRT_BIT  = 6;
  localparam int DSC_BIT  = 7;
  localparam int RX_SYNC_DELAY_LSB = 8;
  localparam int SDM_LSB  = 10;

  localparam logic [7:0]  RST_COMMAND     = 8'h00;
  localparam logic [7:0]  RST_GLOBAL_MODE = 8'h00;
  localparam logic [31:0] RST_TDM_MODE    = 32'h0000_0000;
  localparam logic [31:0] RST_CLOCK_ROUTE = 32'h0000_0000;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

  // ----------------------------------------------------------------
  // channel select codes and states
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_NONE   = 3'h0;
  localparam logic [2:0] CH_STROBE = 3'h7;

  typedef struct packed {
    logic [1:0] switch_tx_rx;
    logic [3:0] strobe_select;
    logic       spare;
    logic [2:0] channel_select;
    logic [3:0] slot_length;
    logic       unit_is_byte;
    logic       last_entry;
  } tsa_entry_t;

  typedef struct packed {
    logic [2:0] strobe;
    logic [5:0] chan_en;
  } tsa_slot_out_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_LOAD  = 2'b10,
    ST_RUN   = 2'b11
  } tsa_state_t;

endpackage

// ===== design/tsa_slot_assigner.sv
`timescale 1ns/100ps
module tsa_slot_assigner
  import tsa_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [8:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // tdm link
  input  wire logic        tdm_rx_clock_i,
  input  wire logic        tdm_rx_sync_i,
  input  wire logic        tdm_rx_data_i,
  input  wire logic        tx_grant_i,
  output logic             tdm_tx_data_o,
  output logic             tdm_tx_data_oe_o,
  // strobes and channel side
  output logic             codec_strobe_one_o,
  output logic             codec_strobe_two_o,
  output logic             codec_strobe_three_o,
  output logic      [5:0]  chan_en_o,
  output logic             rx_bit_o,
  output logic             rx_bit_valid_o,
  input  wire logic [5:0]  chan_tx_bit_i
);

  // ----------------------------------------------------------------
  // registers and routing memory
  // ----------------------------------------------------------------
  logic [ENTRY_W-1:0] route_mem [DEPTH];
  logic [7:0]  command, next_command;
  logic [7:0]  global_mode, next_global_mode;
  logic [31:0] tdm_mode, next_tdm_mode;
  logic [31:0] clock_route, next_clock_route;
  logic        use_shadow, next_use_shadow;
  logic        switch_pend, next_switch_pend;
  logic [31:0] next_rdata;

  function automatic logic [7:0] route_base(input logic shadow, input logic tx);
    route_base = tx ? (shadow ? TX_SHD_BASE : TX_CUR_BASE)
                    : (shadow ? RX_SHD_BASE : RX_CUR_BASE);
  endfunction

  wire logic tdm_on  = (global_mode == GMODE_FIRST_ON);
  wire logic common_timing     = tdm_mode[CRT_BIT];
  wire logic double_speed_clock     = tdm_mode[DSC_BIT];
  wire logic ce      = tdm_mode[CE_BIT];
  wire logic fe      = tdm_mode[FE_BIT];
  wire logic gm      = tdm_mode[GM_BIT];
  wire logic tx_zero_idle     = tdm_mode[STZ_BIT];
  wire logic [1:0] rx_sync_delay = tdm_mode[RX_SYNC_DELAY_LSB +: 2];
  wire logic [1:0] tx_sync_delay = tdm_mode[TX_SYNC_DELAY_LSB +: 2];
  wire logic [1:0] diagnostic_mode  = tdm_mode[SDM_LSB +: 2];

  logic frame_start;

  always_comb begin
    next_command     = command;
    next_global_mode = global_mode;
    next_tdm_mode    = tdm_mode;
    next_clock_route = clock_route;
    next_use_shadow  = use_shadow;
    next_switch_pend = switch_pend;
    next_rdata       = 32'h0000_0000;
    // swap only at a frame boundary so no frame mixes two routes
    if (switch_pend && frame_start) begin
      next_use_shadow  = ~use_shadow;
      next_switch_pend = 1'b0;
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_COMMAND: begin
          next_command = reg_wdata_i[7:0];
          if (reg_wdata_i[7:0] == CMD_SWITCH_FIRST) begin
            next_switch_pend = 1'b1;
          end
        end
        ADDR_GLOBAL_MODE: next_global_mode = reg_wdata_i[7:0];
        ADDR_TDM_MODE:    next_tdm_mode    = reg_wdata_i;
        ADDR_CLOCK_ROUTE: next_clock_route = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      if (reg_addr_i[8] == 1'b0) begin
        next_rdata = {16'h0000, route_mem[reg_addr_i[7:0]]};
      end else begin
        unique case (reg_addr_i)
          ADDR_COMMAND:     next_rdata = {24'h000000, command};
          ADDR_GLOBAL_MODE: next_rdata = {24'h000000, global_mode};
          ADDR_TDM_MODE:    next_rdata = tdm_mode;
          ADDR_CLOCK_ROUTE: next_rdata = clock_route;
          ADDR_STATUS:      next_rdata = {30'h0, switch_pend, use_shadow};
          default:          next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      command     <= RST_COMMAND;
      global_mode <= RST_GLOBAL_MODE;
      tdm_mode    <= RST_TDM_MODE;
      clock_route <= RST_CLOCK_ROUTE;
      use_shadow  <= 1'b0;
      switch_pend <= 1'b0;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      command     <= next_command;
      global_mode <= next_global_mode;
      tdm_mode    <= next_tdm_mode;
      clock_route <= next_clock_route;
      use_shadow  <= next_use_shadow;
      switch_pend <= next_switch_pend;
      reg_rdata_o <= next_rdata;
    end
  end

  // memory has no reset: software loads it before enabling the tdm
  always_ff @(posedge ref_clk_i) begin
    if (reg_wr_i && reg_addr_i[8] == 1'b0) begin
      route_mem[reg_addr_i[7:0]] <= reg_wdata_i[ENTRY_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] clk_s, sync_s, dat_s, gnt_s;
  logic       clk_d, sync_d;

  // one clock serves rx and tx when common timing is set; only that is built
  wire logic rise = clk_s[1] & ~clk_d;
  wire logic fall = ~clk_s[1] & clk_d;
  wire logic sync_edge = fe ? rise : fall;
  wire logic tx_edge   = ce ? fall : rise;
  wire logic rx_edge   = ce ? rise : fall;
  // sync as seen on the chosen clock edge; the pin itself moves off that edge
  wire logic next_sync_d = sync_edge ? sync_s[1] : sync_d;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_s  <= 2'b00;
      sync_s <= 2'b00;
      dat_s  <= 2'b00;
      gnt_s  <= 2'b00;
      clk_d  <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      clk_s  <= {clk_s[0], tdm_rx_clock_i};
      sync_s <= {sync_s[0], tdm_rx_sync_i};
      dat_s  <= {dat_s[0], tdm_rx_data_i};
      gnt_s  <= {gnt_s[0], tx_grant_i};
      clk_d  <= clk_s[1];
      sync_d <= next_sync_d;
    end
  end

  // dsc=1 would halve the bit rate; count every other bit edge
  logic half;
  wire logic bit_tick = tx_edge & (~double_speed_clock | half);
  assign frame_start = sync_edge & sync_s[1] & ~sync_d;

  // ----------------------------------------------------------------
  // slot sequencer
  // ----------------------------------------------------------------
  tsa_state_t  state, next_state;
  logic [5:0]  idx, next_idx;
  logic [6:0]  bits_left, next_bits_left;
  logic [1:0]  dly, next_dly;
  tsa_entry_t  cur, next_cur;
  logic        next_half;

  wire tsa_entry_t rd_entry =
    tsa_entry_t'(route_mem[route_base(use_shadow, 1'b0) + {2'b00, idx}]);
  wire logic [6:0] slot_bits = rd_entry.unit_is_byte ?
    7'({3'h0, rd_entry.slot_length} * 7'(BITS_PER_BYTE) + 7'(BITS_PER_BYTE)) :
    7'({3'h0, rd_entry.slot_length} + 7'h1);

  always_comb begin
    next_state     = state;
    next_idx       = idx;
    next_bits_left = bits_left;
    next_dly       = dly;
    next_cur       = cur;
    next_half      = tx_edge ? ~half : half;
    if (!tdm_on || diagnostic_mode != 2'b00 || !common_timing) begin
      next_state = ST_IDLE;
    end else if (frame_start) begin
      next_idx   = 6'h00;
      next_dly   = (rx_sync_delay > tx_sync_delay) ? rx_sync_delay : tx_sync_delay;
      next_state = ST_DELAY;
      next_half  = 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: ;
        ST_DELAY: begin
          if (dly == 2'b00) begin
            next_state = ST_LOAD;
          end else if (bit_tick) begin
            next_dly = dly - 2'b01;
          end
        end
        ST_LOAD: begin
          next_cur       = rd_entry;
          next_bits_left = slot_bits;
          next_state     = ST_RUN;
        end
        ST_RUN: begin
          if (bit_tick) begin
            if (bits_left == 7'h01) begin
              if (cur.last_entry) begin
                next_state = ST_IDLE;
              end else begin
                next_idx   = idx + 6'h01;
                next_state = ST_LOAD;
              end
            end else begin
              next_bits_left = bits_left - 7'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= ST_IDLE;
      idx       <= 6'h00;
      bits_left <= 7'h00;
      dly       <= 2'b00;
      cur       <= '0;
      half      <= 1'b0;
    end else begin
      state     <= next_state;
      idx       <= next_idx;
      bits_left <= next_bits_left;
      dly       <= next_dly;
      cur       <= next_cur;
      half      <= next_half;
    end
  end

  // ----------------------------------------------------------------
  // outputs: strobes, channel enables, data
  // ----------------------------------------------------------------
  // strobes are held through ST_LOAD so two entries with one strobe do not glitch
  wire logic in_slot = (state == ST_RUN) || (state == ST_LOAD && idx != 6'h00);
  tsa_slot_out_t slot_out;
  logic [5:0] next_en;
  logic       next_txd, next_oe, next_rxb, next_rxv;

  always_comb begin
    slot_out = '0;
    if (in_slot) begin
      unique case (cur.strobe_select[1:0])
        2'b01: slot_out.strobe = 3'b001;
        2'b10: slot_out.strobe = 3'b010;
        2'b11: slot_out.strobe = 3'b100;
        default: slot_out.strobe = 3'b000;
      endcase
      if (cur.channel_select != CH_NONE && cur.channel_select != CH_STROBE) begin
        slot_out.chan_en = 6'(6'h01 << (cur.channel_select - 3'h1));
      end
    end
    next_en  = (state == ST_RUN) ? slot_out.chan_en : 6'h00;
    next_txd = tdm_tx_data_o;
    next_oe  = tdm_tx_data_oe_o;
    if (tx_edge) begin
      // open drain: drive only a zero, release for a one; grant gates slot driving, not the stz idle zeros
      next_txd = 1'b0;
      next_oe  = (state == ST_RUN) && (|next_en) && (!gm || gnt_s[1]) &&
                 !(|(chan_tx_bit_i & next_en));
      if (state != ST_RUN && tx_zero_idle) begin
        next_oe = 1'b1;
      end
    end
    next_rxb = dat_s[1];
    next_rxv = rx_edge && (state == ST_RUN) && (|next_en);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      codec_strobe_one_o   <= 1'b0;
      codec_strobe_two_o   <= 1'b0;
      codec_strobe_three_o <= 1'b0;
      chan_en_o            <= 6'h00;
      tdm_tx_data_o        <= 1'b0;
      tdm_tx_data_oe_o     <= 1'b0;
      rx_bit_o             <= 1'b0;
      rx_bit_valid_o       <= 1'b0;
    end else begin
      codec_strobe_one_o   <= slot_out.strobe[0];
      codec_strobe_two_o   <= slot_out.strobe[1];
      codec_strobe_three_o <= slot_out.strobe[2];
      chan_en_o            <= next_en;
      tdm_tx_data_o        <= next_txd;
      tdm_tx_data_oe_o     <= next_oe;
      rx_bit_o             <= next_rxb;
      rx_bit_valid_o       <= next_rxv;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_cmd_arms_switch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == ADDR_COMMAND && reg_wdata_i[7:0] == CMD_SWITCH_FIRST
    |=> switch_pend || $changed(use_shadow))
    else $error("switch command not armed");
  a_off_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !tdm_on |=> state == ST_IDLE)
    else $error("sequencer ran while tdm disabled");
  a_sync_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    frame_start && tdm_on && diagnostic_mode == 2'b00 && common_timing |=> idx == 6'h00 && state == ST_DELAY)
    else $error("frame did not restart at first entry");
  a_last_stops: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state == ST_RUN && bit_tick && bits_left == 7'h01 && cur.last_entry && !frame_start
    && tdm_on && diagnostic_mode == 2'b00 && common_timing |=> state == ST_IDLE)
    else $error("route ran past last entry");
  a_len_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state == ST_LOAD && !frame_start && tdm_on && diagnostic_mode == 2'b00 && common_timing |=> bits_left ==
    (cur.unit_is_byte ? 7'({3'h0, cur.slot_length} * 7'h8 + 7'h8)
                      : 7'({3'h0, cur.slot_length} + 7'h1)))
    else $error("slot length wrong");
  a_strobe_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state == ST_LOAD && idx != 6'h00 && cur.strobe_select[1:0] == 2'b01 && !frame_start &&
    rd_entry.strobe_select[1:0] == 2'b01 && tdm_on && diagnostic_mode == 2'b00 && common_timing
    |=> codec_strobe_one_o ##1 codec_strobe_one_o)
    else $error("strobe dropped between entries");
  a_grant_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    gm && !gnt_s[1] && tx_edge && state == ST_RUN |=> !tdm_tx_data_oe_o)
    else $error("drove tx data without grant");
  a_txd_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    tdm_tx_data_oe_o |-> !tdm_tx_data_o)
    else $error("open drain pin drove a one");

endmodule

// ===== verif/tsa_xcvr_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// line transceiver model: bit clock, frame sync, receive data
// ------------------------------------------------------------
module tsa_xcvr_model #(
  parameter int FRAME_BITS = 193,
  parameter int HALF_NS    = 200,
  parameter int START_NS   = 137
) (
  // control
  input  wire logic run_i,
  input  wire logic strobe_i,
  // link
  output logic      link_clk_o,
  output logic      sync_o,
  output logic      data_o,
  output logic      codec_en_o
);
  // codec transmit and receive enables share one long strobe
  assign codec_en_o = strobe_i;

  // sync moves after the falling edge for the rising-edge sampler; data moves after
  // the rising edge because the block samples it on the falling edge
  initial begin
    link_clk_o = 1'b0;
    sync_o     = 1'b0;
    data_o     = 1'b0;
    #START_NS;
    forever begin
      if (!run_i) begin
        #HALF_NS;
      end else begin
        for (int b = 0; b < FRAME_BITS; b++) begin
          sync_o = (b == 0);
          #HALF_NS link_clk_o = 1'b1;
          data_o = b[0] ^ b[3];
          #HALF_NS link_clk_o = 1'b0;
        end
      end
    end
  end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import tsa_pkg::*;
  // ------------------------------------------------------------
  // setup
  // ------------------------------------------------------------
  localparam int          BIT_CYC = 8;
  localparam logic [31:0] M0      = (32'h1 << GM_BIT) | (32'h1 << FE_BIT) | (32'h1 << CRT_BIT);
  localparam logic [31:0] M1      = M0 | (32'h1 << TX_SYNC_DELAY_LSB) | (32'h1 << RX_SYNC_DELAY_LSB);
  logic        ref_clk_i;
  logic        rst_i;
  logic [8:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic        link_clk, sync, rxd, txd, txoe, s1, s2, s3, rx_bit, rx_vld, codec_en;
  logic        sync_q;
  logic        grant;
  logic [5:0]  chan_en;
  logic [10:0] mon;
  logic [10:0] mon_q;
  // 0..12 live route, 13 stray entry past the last one, 14 shadow route
  logic [15:0] rt [15] = '{16'h0046, 16'h0002, 16'h0082, 16'h00d6, 16'h0116, 16'h05cc,
                           16'h05cc, 16'h09cc, 16'h000c, 16'h0dc2, 16'h0142, 16'h0182,
                           16'h0003, 16'h0dc6, 16'h09c3};
  int          n_errors, checks_done, cyc, since, dly, d1;
  int          hi[11], rs[11], h0[11], r0[11], fh[11], fr[11];

  tsa_slot_assigner dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tdm_rx_clock_i(link_clk), .tdm_rx_sync_i(sync),
    .tdm_rx_data_i(rxd), .tx_grant_i(grant), .tdm_tx_data_o(txd), .tdm_tx_data_oe_o(txoe),
    .codec_strobe_one_o(s1), .codec_strobe_two_o(s2), .codec_strobe_three_o(s3),
    .chan_en_o(chan_en), .rx_bit_o(rx_bit), .rx_bit_valid_o(rx_vld), .chan_tx_bit_i(6'h00));

  tsa_xcvr_model xcvr_u (
    .run_i(1'b1), .strobe_i(s1), .link_clk_o(link_clk), .sync_o(sync), .data_o(rxd),
    .codec_en_o(codec_en));

  assign mon = {rx_vld, txoe, chan_en, s3, s2, s1};

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic bad(input string m);
    $display("BAD %0t %s", $time, m);
    n_errors++;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) bad($sformatf("read %h expected %h", got, exp));
  endtask

  task automatic near(input int got, input int exp, input int tol, input string m);
    checks_done++;
    if (got < exp - tol || got > exp + tol) bad($sformatf("%s got %0d expected %0d", m, got, exp));
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // per-cycle high and run counts of every slot output; open-drain line never driven high
  always @(posedge ref_clk_i) begin
    cyc++;
    since = (sync && !sync_q) ? 0 : since + 1;
    for (int i = 0; i < 11; i++) begin
      if (mon[i] === 1'b1) hi[i]++;
      if (mon[i] === 1'b1 && mon_q[i] !== 1'b1) rs[i]++;
    end
    if (chan_en[0] === 1'b1 && mon_q[3] !== 1'b1) dly = since;
    if (txoe === 1'b1 && txd !== 1'b0) bad("tx line driven high");
    // line data holds from one rising link edge to the next, so it still stands here
    if (rx_vld === 1'b1 && rx_bit !== rxd) bad("rx bit differs from line");
    mon_q = mon;
    sync_q = sync;
    if (cyc == 40000) begin
      bad("timeout");
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // register port and frame tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask

  // sync edges never meet a clock edge, so snapshots cannot race the counters
  task automatic frame();
    @(posedge sync);
    h0 = hi;
    r0 = rs;
    @(posedge sync);
    foreach (fh[i]) begin
      fh[i] = hi[i] - h0[i];
      fr[i] = rs[i] - r0[i];
    end
  endtask

  // tx_ok low: grant withheld, so the open-drain line must stay released
  task automatic check_route(input int base, input int n, input bit tx_ok = 1'b1);
    int ex[11];
    int bits;
    tsa_entry_t e;
    ex = '{default: 0};
    for (int k = base; k < base + n; k++) begin
      e = tsa_entry_t'(rt[k]);
      bits = (int'(e.slot_length) + 1) * (e.unit_is_byte ? 8 : 1) * BIT_CYC;
      if (e.strobe_select inside {4'h1, 4'h2, 4'h3}) ex[e.strobe_select - 4'h1] += bits;
      if (e.channel_select inside {[3'h1 : 3'h6]}) begin
        ex[int'(e.channel_select) + 2] += bits;
        if (tx_ok) ex[9] += bits;
        ex[10] += bits / BIT_CYC;
      end
    end
    for (int i = 0; i < 11; i++) begin
      near(fh[i], ex[i], 2, "slot cycles");
      if (i < 9) near(fr[i], (ex[i] > 0) ? 1 : 0, 0, "slot runs");
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_i       = 1'b1;
    reg_addr_i  = 9'h000;
    reg_wdata_i = 32'h0000_0000;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    grant       = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(ADDR_COMMAND, {24'h0, RST_COMMAND});
    rd(ADDR_GLOBAL_MODE, {24'h0, RST_GLOBAL_MODE});
    rd(ADDR_TDM_MODE, RST_TDM_MODE);
    rd(ADDR_CLOCK_ROUTE, RST_CLOCK_ROUTE);
    wr(9'h1ff, 32'hffff_ffff);
    rd(9'h1ff, 32'h0000_0000);
    for (int k = 0; k < 14; k++) begin
      wr(9'(RX_CUR_BASE) + 9'(k), {16'h0, rt[k]});
      wr(9'(TX_CUR_BASE) + 9'(k), {16'h0, rt[k]});
    end
    wr(9'(RX_SHD_BASE), {16'h0, rt[14]});
    wr(9'(TX_SHD_BASE), {16'h0, rt[14]});
    rd(9'(RX_CUR_BASE) + 9'd5, {16'h0, rt[5]});
    rd(9'(TX_SHD_BASE), {16'h0, rt[14]});
    wr(ADDR_TDM_MODE, M1);
    wr(ADDR_CLOCK_ROUTE, 32'h4040_4040);
    rd(ADDR_CLOCK_ROUTE, 32'h4040_4040);
    frame();
    check_route(0, 0);
    wr(ADDR_GLOBAL_MODE, {24'h0, GMODE_FIRST_ON});
    rd(ADDR_GLOBAL_MODE, {24'h0, GMODE_FIRST_ON});
    rd(ADDR_TDM_MODE, M1);
    repeat (2) begin
      frame();
      check_route(0, 13);
    end
    d1 = dly;
    wr(ADDR_TDM_MODE, M1 | (32'h1 << SDM_LSB));
    frame();
    check_route(0, 0);
    wr(ADDR_TDM_MODE, M0);
    frame();
    check_route(0, 13);
    near(d1 - dly, BIT_CYC, 1, "frame delay");
    @(posedge ref_clk_i);
    grant <= 1'b0;
    frame();
    check_route(0, 13, 1'b0);
    @(posedge ref_clk_i);
    grant <= 1'b1;
    wr(ADDR_COMMAND, {24'h0, CMD_SWITCH_FIRST});
    rd(ADDR_STATUS, 32'h0000_0002);
    frame();
    check_route(14, 1);
    rd(ADDR_STATUS, 32'h0000_0001);
    end_of_test();
  end
endmodule
